// file: design/mpt_timer.sv
// Design: match based PWM timer with prescaler, seven match registers and PWM outputs
//
// Local design decisions: the address-and-strobe port and the register addresses.
`default_nettype none
// How it works
// - Counter advances from clock; compared against seven match registers for actions.
// - Period match register match resets counter, fixing common PWM cycle rate.
// - Single-edge outputs rise when the period match register matches.
// - Single-edge output programmed constant low never rises.
// - Single-edge mode: one match register per output sets its falling edge.
// - Double-edge mode: two match registers set rise and fall independently.
// - Rise before fall gives positive pulse; fall first gives negative pulse.
// - Up to six single-edge, three double-edge outputs, or any mix.
// - Continuous match keeps counter running, optional interrupt on match.
// - Stop-on-match halts counting, optional interrupt on match.
// - Reset-on-match clears counter, optional interrupt on match.
// - Period and width any count; all outputs share one repetition rate.
// - New match values take effect only at cycle start while running in PWM mode, no truncated pulses.
// - Without PWM mode the block is an ordinary timer, outputs idle.
// - Counter is 32 bits behind a programmable 32-bit prescaler.
module mpt_timer #(
  parameter int CW = 32
) (
  input wire logic clock,
  input wire logic rst,
  input wire mpt_pkg::mpt_bus_req_t bus,
  output logic [31:0] rdata,
  output logic [mpt_pkg::NUM_PWM-1:0] pwm_out,
  output logic irq
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic run;
    logic clr;
    logic pwm_en;
    logic [CW-1:0] count;
    logic [CW-1:0] presc_lim;
    logic [CW-1:0] presc;
    logic [mpt_pkg::NUM_MATCH*mpt_pkg::ACT_BITS-1:0] act;
    logic [mpt_pkg::NUM_PWM-1:0] dbl;
    logic [mpt_pkg::NUM_PWM-1:0] ena;
    logic [mpt_pkg::NUM_MATCH-1:0] rel;
    logic [mpt_pkg::NUM_MATCH*CW-1:0] shadow;
    logic [mpt_pkg::NUM_MATCH*CW-1:0] live;
    logic [mpt_pkg::NUM_MATCH-1:0] ist;
    logic [mpt_pkg::NUM_MATCH-1:0] ien;
    logic [mpt_pkg::NUM_PWM-1:0] pwm;
    logic irq;
    logic [31:0] rdata;
  } mpt_state_t;

  mpt_state_t s_q;
  mpt_state_t s_d;

  // Live match value for index i
  function automatic logic [CW-1:0] live_of(input mpt_state_t s, input int i);
    live_of = s.live[i*CW +: CW];
  endfunction : live_of

  // Write hits a register offset
  function automatic logic hit(input mpt_pkg::mpt_bus_req_t b, input logic [7:0] off);
    hit = b.wr && (b.addr == off);
  endfunction : hit

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic [mpt_pkg::NUM_MATCH-1:0] m;
  logic tick;
  logic do_reset;
  logic do_stop;
  logic [mpt_pkg::NUM_MATCH*mpt_pkg::ACT_BITS-1:0] act_new;
  logic [31:0] rd;
  logic [mpt_pkg::NUM_PWM-1:0] rise;
  logic [mpt_pkg::NUM_PWM-1:0] fall;

  always_comb begin
    s_d = s_q;
    m = '0;
    rise = '0;
    fall = '0;
    rd = 32'h0000_0000;
    act_new = s_q.act;
    // Prescaler wraps at its limit on the same edge as the counter steps
    tick = s_q.run && !s_q.clr && (s_q.presc == s_q.presc_lim);
    do_reset = 1'b0;
    do_stop = 1'b0;
    // Compare on the tick only, so a match acts once per count value
    for (int i = 0; i < mpt_pkg::NUM_MATCH; i++) begin
      m[i] = tick && (s_q.count == live_of(s_q, i));
      if (m[i] && s_q.act[i*mpt_pkg::ACT_BITS + mpt_pkg::ACT_RESET]) begin
        do_reset = 1'b1;
      end
      if (m[i] && s_q.act[i*mpt_pkg::ACT_BITS + mpt_pkg::ACT_STOP]) begin
        do_stop = 1'b1;
      end
    end
    // In PWM mode the period match always resets the count
    if (s_q.pwm_en && m[0]) begin
      do_reset = 1'b1;
    end
    // Prescaler and counter
    if (s_q.clr || !s_q.run) begin
      s_d.presc = s_q.clr ? '0 : s_q.presc;
      s_d.count = s_q.clr ? '0 : s_q.count;
    end else if (tick) begin
      s_d.presc = '0;
      // A stop match freezes the count on the value that matched, unless a reset match in the same tick clears it
      if (do_reset) begin
        s_d.count = '0;
      end else if (!do_stop) begin
        s_d.count = CW'(s_q.count + 1'b1);
      end
    end else begin
      s_d.presc = CW'(s_q.presc + 1'b1);
    end
    if (do_stop) begin
      s_d.run = 1'b0;
    end
    // Released values go live only at cycle start in PWM mode, or at once when stopped or outside PWM mode
    for (int i = 0; i < mpt_pkg::NUM_MATCH; i++) begin
      if (s_q.rel[i] && (m[0] || !s_q.pwm_en || !s_q.run)) begin
        s_d.live[i*CW +: CW] = s_q.shadow[i*CW +: CW];
        s_d.rel[i] = 1'b0;
      end
    end
    // PWM edges: output k uses match k+1; double edge uses k as rise, k+1 as fall
    for (int k = 0; k < mpt_pkg::NUM_PWM; k++) begin
      if (s_q.dbl[k] && k > 0) begin
        rise[k] = m[k];
        fall[k] = m[k+1];
      end else begin
        rise[k] = m[0] && (live_of(s_q, k+1) != '0);
        fall[k] = m[k+1] || (live_of(s_q, k+1) == '0);
      end
      if (!s_q.pwm_en || !s_q.ena[k]) begin
        s_d.pwm[k] = 1'b0;
      end else if (fall[k]) begin
        s_d.pwm[k] = 1'b0;
      end else if (rise[k]) begin
        s_d.pwm[k] = 1'b1;
      end
    end
    // Sticky status: set wins over clear
    for (int i = 0; i < mpt_pkg::NUM_MATCH; i++) begin
      if (m[i] && s_q.act[i*mpt_pkg::ACT_BITS + mpt_pkg::ACT_IRQ]) begin
        s_d.ist[i] = 1'b1;
      end else if (hit(bus, mpt_pkg::OFF_IRQ_CLEAR) && bus.wdata[i]) begin
        s_d.ist[i] = 1'b0;
      end
    end
    // Register writes
    if (hit(bus, mpt_pkg::OFF_CTRL)) begin
      s_d.run = bus.wdata[mpt_pkg::CTRL_RUN_BIT];
      s_d.clr = bus.wdata[mpt_pkg::CTRL_CLR_BIT];
      s_d.pwm_en = bus.wdata[mpt_pkg::CTRL_PWM_BIT];
    end
    if (hit(bus, mpt_pkg::OFF_COUNT)) begin
      s_d.count = bus.wdata[CW-1:0];
    end
    if (hit(bus, mpt_pkg::OFF_PRESC_LIMIT)) begin
      s_d.presc_lim = bus.wdata[CW-1:0];
    end
    if (hit(bus, mpt_pkg::OFF_PRESC_COUNT)) begin
      s_d.presc = bus.wdata[CW-1:0];
    end
    if (hit(bus, mpt_pkg::OFF_MATCH_ACT)) begin
      act_new = bus.wdata[mpt_pkg::NUM_MATCH*mpt_pkg::ACT_BITS-1:0];
      s_d.act = act_new;
    end
    if (hit(bus, mpt_pkg::OFF_PWM_CFG)) begin
      s_d.dbl = bus.wdata[mpt_pkg::NUM_PWM-1:0];
      s_d.ena = bus.wdata[mpt_pkg::CFG_ENA_LSB +: mpt_pkg::NUM_PWM];
    end
    if (hit(bus, mpt_pkg::OFF_RELEASE)) begin
      // Release flags are set here and cleared on transfer; set wins
      s_d.rel = s_d.rel | bus.wdata[mpt_pkg::NUM_MATCH-1:0];
    end
    if (hit(bus, mpt_pkg::OFF_IRQ_ENABLE)) begin
      s_d.ien = bus.wdata[mpt_pkg::NUM_MATCH-1:0];
    end
    for (int i = 0; i < mpt_pkg::NUM_MATCH; i++) begin
      if (hit(bus, 8'(mpt_pkg::OFF_MATCH0 + 4*i))) begin
        s_d.shadow[i*CW +: CW] = bus.wdata[CW-1:0];
      end
    end
    // Reads
    if (bus.rd) begin
      case (bus.addr)
        mpt_pkg::OFF_CTRL: rd = {29'h0000_0000, s_q.pwm_en, s_q.clr, s_q.run};
        mpt_pkg::OFF_COUNT: rd = 32'(s_q.count);
        mpt_pkg::OFF_PRESC_LIMIT: rd = 32'(s_q.presc_lim);
        mpt_pkg::OFF_PRESC_COUNT: rd = 32'(s_q.presc);
        mpt_pkg::OFF_MATCH_ACT: rd = 32'(s_q.act);
        mpt_pkg::OFF_PWM_CFG: rd = {18'h00000, s_q.ena, 2'h0, s_q.dbl};
        mpt_pkg::OFF_RELEASE: rd = 32'(s_q.rel);
        mpt_pkg::OFF_IRQ_STATUS: rd = 32'(s_q.ist);
        mpt_pkg::OFF_IRQ_ENABLE: rd = 32'(s_q.ien);
        default: begin
          rd = 32'h0000_0000;
          for (int i = 0; i < mpt_pkg::NUM_MATCH; i++) begin
            if (bus.addr == 8'(mpt_pkg::OFF_MATCH0 + 4*i)) begin
              rd = 32'(s_q.shadow[i*CW +: CW]);
            end
          end
        end
      endcase
    end
    s_d.rdata = rd;
    s_d.irq = |(s_d.ist & s_d.ien);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign pwm_out = s_q.pwm;
  assign irq = s_q.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_period_reset: assert property (@(posedge clock) disable iff (rst)
    (s_q.pwm_en && m[0] && !bus.wr) |=> (s_q.count == '0))
    else $error("period match did not reset counter");
  chk_stop_halts: assert property (@(posedge clock) disable iff (rst)
    (do_stop && !bus.wr) |=> !s_q.run)
    else $error("stop match did not halt counter");
  chk_count_hold: assert property (@(posedge clock) disable iff (rst)
    (!tick && !s_q.clr && !bus.wr) |=> $stable(s_q.count))
    else $error("counter moved without prescaler wrap");
  chk_irq_level: assert property (@(posedge clock) disable iff (rst)
    (m[0] && s_q.act[mpt_pkg::ACT_IRQ] && s_q.ien[0] && !bus.wr) |=> irq)
    else $error("match interrupt missing");
  chk_pwm_idle: assert property (@(posedge clock) disable iff (rst)
    (!s_q.pwm_en && !bus.wr) |=> (pwm_out == '0))
    else $error("pwm active outside pwm mode");
  chk_unreleased: assert property (@(posedge clock) disable iff (rst)
    (!s_q.rel[1] && !bus.wr) |=> $stable(s_q.live[CW +: CW]))
    else $error("unreleased match value went live");
  chk_sync_update: assert property (@(posedge clock) disable iff (rst)
    (s_q.pwm_en && s_q.run && !m[0] && !bus.wr) |=> $stable(s_q.live))
    else $error("match value changed mid cycle");
  chk_single_rise: assert property (@(posedge clock) disable iff (rst)
    (s_q.pwm_en && s_q.ena[1] && !s_q.dbl[1] && m[0] && !m[2] && live_of(s_q, 2) != '0
    && !bus.wr) |=> pwm_out[1])
    else $error("single edge output did not rise");
  chk_const_low: assert property (@(posedge clock) disable iff (rst)
    (!s_q.dbl[0] && live_of(s_q, 1) == '0 && !bus.wr) |=> !pwm_out[0])
    else $error("constant low output rose");

  // ----------------------------------------
  // Checks: counter and prescaler
  // ----------------------------------------
  // Prescaler steps by one between wraps
  chk_presc_step: assert property (@(posedge clock) disable iff (rst)
    (s_q.run && !s_q.clr && !tick && !bus.wr)
    |=> (s_q.presc == CW'($past(s_q.presc) + 1'b1)))
    else $error("prescaler did not step");
  // Wrap returns the prescaler to zero
  chk_presc_wrap: assert property (@(posedge clock) disable iff (rst)
    (tick && !bus.wr) |=> (s_q.presc == '0))
    else $error("prescaler did not wrap");
  // Clear bit pins count and prescaler at zero
  chk_clear_hold: assert property (@(posedge clock) disable iff (rst)
    (s_q.clr && !bus.wr) |=> (s_q.count == '0 && s_q.presc == '0))
    else $error("clear bit did not hold counter");
  // A match with no reset or stop action leaves the count running
  chk_keep_running: assert property (@(posedge clock) disable iff (rst)
    (tick && !do_reset && !do_stop && !bus.wr)
    |=> (s_q.count == CW'($past(s_q.count) + 1'b1)))
    else $error("counter did not advance on tick");
  // Stop leaves the count on the value that matched
  chk_stop_freeze: assert property (@(posedge clock) disable iff (rst)
    (do_stop && !do_reset && !bus.wr) |=> $stable(s_q.count))
    else $error("count moved past stop match");
  // Reset action clears the count on the tick
  chk_reset_clear: assert property (@(posedge clock) disable iff (rst)
    (do_reset && !bus.wr) |=> (s_q.count == '0))
    else $error("reset match did not clear counter");
  // Once inside the period the count stays there, so every output shares one rate
  chk_period_bound: assert property (@(posedge clock) disable iff (rst)
    (s_q.pwm_en && s_q.run && !s_q.rel[0] && s_q.count <= live_of(s_q, 0) && !bus.wr)
    |=> (s_q.count <= live_of(s_q, 0)))
    else $error("count ran past the period");
  // Mode bit follows the control write
  chk_ctrl_mode: assert property (@(posedge clock) disable iff (rst)
    hit(bus, mpt_pkg::OFF_CTRL)
    |=> (s_q.pwm_en == $past(bus.wdata[mpt_pkg::CTRL_PWM_BIT])))
    else $error("pwm mode bit not taken");

  // ----------------------------------------
  // Checks: PWM edges
  // ----------------------------------------
  // Single edge output drops on its own match
  chk_single_fall: assert property (@(posedge clock) disable iff (rst)
    (s_q.pwm_en && s_q.ena[1] && !s_q.dbl[1] && m[2] && !bus.wr) |=> !pwm_out[1])
    else $error("single edge output did not fall");
  // Double edge output rises on its rising match
  chk_dbl_rise: assert property (@(posedge clock) disable iff (rst)
    (s_q.pwm_en && s_q.ena[3] && s_q.dbl[3] && m[3] && !m[4] && !bus.wr) |=> pwm_out[3])
    else $error("double edge output did not rise");
  // Double edge output falls on its falling match
  chk_dbl_fall: assert property (@(posedge clock) disable iff (rst)
    (s_q.pwm_en && s_q.ena[3] && s_q.dbl[3] && m[4] && !bus.wr) |=> !pwm_out[3])
    else $error("double edge output did not fall");
  // Negative pulse: the rise comes late in the cycle
  chk_neg_rise: assert property (@(posedge clock) disable iff (rst)
    (s_q.pwm_en && s_q.ena[4] && s_q.dbl[4] && m[4] && !m[5] && !bus.wr) |=> pwm_out[4])
    else $error("negative pulse did not rise");
  // Negative pulse: the fall comes early in the cycle
  chk_neg_fall: assert property (@(posedge clock) disable iff (rst)
    (s_q.pwm_en && s_q.ena[4] && s_q.dbl[4] && m[5] && !bus.wr) |=> !pwm_out[4])
    else $error("negative pulse did not fall");
  // A disabled output stays low whatever its matches do
  chk_disabled_low: assert property (@(posedge clock) disable iff (rst)
    (!s_q.ena[2] && !bus.wr) |=> !pwm_out[2])
    else $error("disabled output went high");

  // ----------------------------------------
  // Checks: interrupts and release
  // ----------------------------------------
  // Match with its interrupt action sets the sticky bit, clear or not
  chk_status_set: assert property (@(posedge clock) disable iff (rst)
    (m[1] && s_q.act[mpt_pkg::ACT_BITS + mpt_pkg::ACT_IRQ]) |=> s_q.ist[1])
    else $error("match did not set status");
  // Clear write drops the status bit when no match competes
  chk_status_clear: assert property (@(posedge clock) disable iff (rst)
    (hit(bus, mpt_pkg::OFF_IRQ_CLEAR) && bus.wdata[0] && !m[0]) |=> !s_q.ist[0])
    else $error("status bit not cleared");
  // With every enable off the interrupt line is low
  chk_irq_masked: assert property (@(posedge clock) disable iff (rst)
    (s_q.ien == '0 && !bus.wr) |=> !irq)
    else $error("masked interrupt raised");
  // Released value goes live at once while the timer is stopped
  chk_live_idle: assert property (@(posedge clock) disable iff (rst)
    (s_q.rel[0] && !s_q.run && !bus.wr) |=> !s_q.rel[0])
    else $error("idle release did not go live");
  // Released value goes live at the period match while running in PWM mode
  chk_release_live: assert property (@(posedge clock) disable iff (rst)
    (s_q.rel[2] && s_q.pwm_en && s_q.run && m[0] && !bus.wr)
    |=> (s_q.live[2*CW +: CW] == $past(s_q.shadow[2*CW +: CW])))
    else $error("released value not live at cycle start");
endmodule : mpt_timer
`default_nettype wire

// file: include/mpt_pkg.sv
// Package: register map, field layouts and types of the match based PWM timer
`default_nettype none
package mpt_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_PRESC_LIMIT = 8'h08;
  localparam logic [7:0] OFF_PRESC_COUNT = 8'h0C;
  localparam logic [7:0] OFF_MATCH_ACT = 8'h10;
  localparam logic [7:0] OFF_PWM_CFG = 8'h14;
  localparam logic [7:0] OFF_RELEASE = 8'h18;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h20;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h24;
  localparam logic [7:0] OFF_MATCH0 = 8'h40;
  // ----------------------------------------
  // Field positions and sizes
  // ----------------------------------------
  localparam int NUM_MATCH = 7;
  localparam int NUM_PWM = 6;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam int CTRL_PWM_BIT = 2;
  localparam int ACT_BITS = 3;
  localparam int ACT_IRQ = 0;
  localparam int ACT_RESET = 1;
  localparam int ACT_STOP = 2;
  localparam int CFG_ENA_LSB = 8;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [6:0] RST_MASK7 = 7'h00;
  localparam logic [5:0] RST_PWM6 = 6'h00;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mpt_bus_req_t;
endpackage : mpt_pkg
`default_nettype wire

// file: tb/mpt_load.sv
// Load model: counts clocks that each PWM pin spends high while measuring
`default_nettype none
module mpt_load (
  input wire logic clock,
  input wire logic meas,
  input wire logic [5:0] pwm,
  output logic [5:0][15:0] hi_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // Plain loads only; the tally clears whenever measuring stops
  always_ff @(posedge clock) begin
    for (int k = 0; k < 6; k++) begin
      hi_cnt[k] <= meas ? hi_cnt[k] + 16'(pwm[k]) : 16'h0000;
    end
  end
endmodule : mpt_load
`default_nettype wire

// file: tb/testbench.sv
// Testbench: random and corner scenarios for the match based PWM timer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic meas = 1'b0;
  mpt_pkg::mpt_bus_req_t bus = '0;
  logic [31:0] rdata;
  logic [5:0] pwm_out;
  logic irq;
  logic [5:0][15:0] hi_cnt;
  int n_errors = 0;
  int num_checks = 0;
  int lim;
  int w;
  mpt_timer #(.CW(32)) i_dut (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata),
    .pwm_out(pwm_out), .irq(irq));
  mpt_load i_load (.clock(clock), .meas(meas), .pwm(pwm_out), .hi_cnt(hi_cnt));
  // ----------------------------------------
  // Clock, compares and bus cycles
  // ----------------------------------------
  initial begin
    forever #25 clock = ~clock;
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_pin(input int k, input int exp);
    chk_word(32'(hi_cnt[k]), 32'(exp));
  endtask : chk_pin
  task automatic chk_irq(input logic exp);
    chk_word({31'h0, irq}, {31'h0, exp});
  endtask : chk_irq
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd
  // High clocks over three periods of 11 counts; both edges share latency
  function automatic int hi_exp(input int r, input int f);
    return ((f - r + 11) % 11) * 3 * (lim + 1);
  endfunction : hi_exp
  // Window spans whole periods, so phase of the start does not matter
  task automatic measure;
    repeat (22 * (lim + 1)) @(posedge clock);
    meas <= 1'b1;
    repeat (33 * (lim + 1)) @(posedge clock);
    meas <= 1'b0;
    #1;
  endtask : measure
  task automatic tally_and_finish;
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // Watchdog well beyond the fewer than a thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    tally_and_finish();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] v;
    logic [7:0] offs [8];
    offs = '{mpt_pkg::OFF_CTRL, mpt_pkg::OFF_COUNT, mpt_pkg::OFF_PRESC_LIMIT,
      mpt_pkg::OFF_MATCH_ACT, mpt_pkg::OFF_PWM_CFG, mpt_pkg::OFF_IRQ_STATUS,
      mpt_pkg::OFF_IRQ_ENABLE, 8'h30};
    void'($urandom(83));
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    lim = $urandom % 3;
    w = $urandom % 8 + 1;
    // Reset values and an unmapped place read back zero
    wr(8'h30, 32'hFFFF_FFFF);
    for (int i = 0; i < 8; i++) begin
      rd(offs[i], v);
      chk_word(v, mpt_pkg::RST_WORD);
    end
    // Stop on match with interrupt, through a random prescale
    wr(mpt_pkg::OFF_PRESC_LIMIT, 32'(lim));
    wr(mpt_pkg::OFF_MATCH0 + 8'h04, 32'h5);
    wr(mpt_pkg::OFF_MATCH_ACT, 32'h28);
    wr(mpt_pkg::OFF_RELEASE, 32'h7F);
    wr(mpt_pkg::OFF_IRQ_ENABLE, 32'h2);
    wr(mpt_pkg::OFF_CTRL, 32'h1);
    repeat (14 * (lim + 1)) @(posedge clock);
    rd(mpt_pkg::OFF_COUNT, v);
    chk_word(v, 32'h5);
    rd(mpt_pkg::OFF_IRQ_STATUS, v);
    chk_word(v, 32'h2);
    chk_irq(1'b1);
    wr(mpt_pkg::OFF_CTRL, 32'h0);
    wr(mpt_pkg::OFF_IRQ_CLEAR, 32'h2);
    rd(mpt_pkg::OFF_IRQ_STATUS, v);
    chk_word(v, 32'h0);
    chk_irq(1'b0);
    // Full width count reads back; clear bit zeroes count and prescaler
    wr(mpt_pkg::OFF_COUNT, 32'hFFFF_FFFF);
    rd(mpt_pkg::OFF_COUNT, v);
    chk_word(v, 32'hFFFF_FFFF);
    wr(mpt_pkg::OFF_PRESC_COUNT, 32'h1);
    wr(mpt_pkg::OFF_CTRL, 32'h3);
    rd(mpt_pkg::OFF_COUNT, v);
    chk_word(v, 32'h0);
    rd(mpt_pkg::OFF_PRESC_COUNT, v);
    chk_word(v, 32'h0);
    wr(mpt_pkg::OFF_CTRL, 32'h0);
    // Reset on the period match; interrupt raised then masked
    wr(mpt_pkg::OFF_COUNT, 32'h0);
    wr(mpt_pkg::OFF_MATCH_ACT, 32'h3);
    wr(mpt_pkg::OFF_MATCH0, 32'h6);
    wr(mpt_pkg::OFF_RELEASE, 32'h7F);
    wr(mpt_pkg::OFF_IRQ_ENABLE, 32'h1);
    wr(mpt_pkg::OFF_CTRL, 32'h1);
    repeat (30 * (lim + 1)) @(posedge clock);
    rd(mpt_pkg::OFF_COUNT, v);
    chk_word({31'h0, v <= 32'h6}, 32'h1);
    rd(mpt_pkg::OFF_IRQ_STATUS, v);
    chk_word(v, 32'h1);
    chk_irq(1'b1);
    wr(mpt_pkg::OFF_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge clock);
    chk_irq(1'b0);
    wr(mpt_pkg::OFF_CTRL, 32'h0);
    wr(mpt_pkg::OFF_IRQ_CLEAR, 32'h1);
    // Mixed outputs: 0 constant low, 1 single, 3 positive, 4 negative
    wr(mpt_pkg::OFF_COUNT, 32'h0);
    wr(mpt_pkg::OFF_MATCH_ACT, 32'h2);
    wr(mpt_pkg::OFF_MATCH0, 32'hA);
    wr(mpt_pkg::OFF_MATCH0 + 8'h04, 32'h0);
    wr(mpt_pkg::OFF_MATCH0 + 8'h08, 32'(w));
    wr(mpt_pkg::OFF_MATCH0 + 8'h0C, 32'h2);
    wr(mpt_pkg::OFF_MATCH0 + 8'h10, 32'h7);
    wr(mpt_pkg::OFF_MATCH0 + 8'h14, 32'h3);
    wr(mpt_pkg::OFF_PWM_CFG, 32'h1B18);
    wr(mpt_pkg::OFF_RELEASE, 32'h7F);
    wr(mpt_pkg::OFF_CTRL, 32'h1);
    measure();
    for (int k = 0; k < 6; k++) begin
      chk_pin(k, 0);
    end
    wr(mpt_pkg::OFF_CTRL, 32'h5);
    measure();
    chk_pin(0, 0);
    chk_pin(1, hi_exp(10, w));
    chk_pin(3, hi_exp(2, 7));
    chk_pin(4, hi_exp(7, 3));
    // New width ignored until released, then live at a cycle start
    wr(mpt_pkg::OFF_MATCH0 + 8'h08, 32'(w + 1));
    measure();
    chk_pin(1, hi_exp(10, w));
    wr(mpt_pkg::OFF_RELEASE, 32'h4);
    measure();
    chk_pin(1, hi_exp(10, w + 1));
    chk_pin(3, hi_exp(2, 7));
    rd(mpt_pkg::OFF_RELEASE, v);
    chk_word(v, 32'h0);
    // Reset in mid-run drops every output at once
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk_word({26'h0, pwm_out}, 32'h0);
    chk_irq(1'b0);
    rd(mpt_pkg::OFF_CTRL, v);
    chk_word(v, 32'h0);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
